/* File: lsg_defines.svh */
// lsg_defines.svh: offsets, field positions, reset values and build defaults of the
// pseudo-random sequence generator.
// assumes inclusion by bare name from every design file that needs a constant.
//
// How it works
// - with the chained structure, one feedback gate at the head combines every tapped register and feeds the first register.
// - with the distributed structure, each tap has its own gate mixing the last register with the bit entering that position.
// - the gate kind, exclusive-or or exclusive-nor, is fixed at build time and used at every feedback point.
// - the chain length is a build-time parameter that also sizes the parallel seed input and the parallel output.
// - the tap polynomial is a hex constant whose lowest bit must be 1, the top term being implied and left out.
// - the sequence starts from a build-time seed constant.
// - a build-time option decides whether a run-time seed input exists that can replace the chain contents.
// - a reloaded seed arrives either whole on a port as wide as the chain or one bit at a time on a serial input.
// - the output is either every chain bit in parallel or only the last bit, by a build-time option.
// - a load with seed data overwrites the chain, and stepping then carries on from the loaded value with the same settings.
// - the restart input puts back the build-time seed and stepping resumes once it is released.
// - while enable is low and neither load nor restart is asked, the chain holds its value, and stepping resumes when enable returns high.

`ifndef LSG_DEFINES_SVH
`define LSG_DEFINES_SVH

// ----------------------------------------------------------------------------
// build defaults
// ----------------------------------------------------------------------------
`define LSG_DEF_WIDTH      8
`define LSG_DEF_POLY       8'h1D
`define LSG_DEF_SEED       8'h01
`define LSG_DEF_FIFO_DEPTH 8

// ----------------------------------------------------------------------------
// register port: byte offsets, fields, reset values
// ----------------------------------------------------------------------------
`define LSG_REG_AW         4
`define LSG_OFF_CTRL       4'h0
`define LSG_OFF_STATE      4'h4
`define LSG_OFF_LEVEL      4'h8
`define LSG_CTRL_RUN_BIT   0
`define LSG_CTRL_RST_BIT   1
`define LSG_CTRL_RUN_RST   1'h1

`endif

/* File: lsg_pkg.sv */
// lsg_pkg.sv: types shared by the sequence generator files.
// assumes nothing of its surroundings.

package lsg_pkg;

	// feedback structure, one-hot
	typedef enum logic [1:0] {
		LSG_FIB = 2'h1,
		LSG_GAL = 2'h2
	} lsg_struct_e;

	// feedback gate kind, one-hot
	typedef enum logic [1:0] {
		LSG_XOR  = 2'h1,
		LSG_XNOR = 2'h2
	} lsg_gate_e;

	// what the chain does on the next edge, one-hot
	typedef enum logic [3:0] {
		LSG_ACT_HOLD    = 4'h1,
		LSG_ACT_RESTART = 4'h2,
		LSG_ACT_LOAD    = 4'h4,
		LSG_ACT_STEP    = 4'h8
	} lsg_act_e;

endpackage

/* File: lsg_mem.sv */
// lsg_mem.sv: small storage for the output queue, one write and one read port.
// assumes one clock; read data are registered and a write to the read address
// in the same cycle is forwarded.

`timescale 1ns/10ps
`default_nettype none

module lsg_mem #(
	parameter int unsigned DW = 8,
	parameter int unsigned AW = 3
) (
	// clock
	input  wire logic          clk_i,
	// write side
	input  wire logic          wr_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [DW-1:0] wdata_i,
	// read side
	input  wire logic [AW-1:0] raddr_i,
	output logic      [DW-1:0] rdata_o
);

	logic [DW-1:0] mem_reg [(1 << AW)];

	always_ff @(posedge clk_i)
	begin
		if (wr_i)
		begin
			mem_reg[waddr_i] <= wdata_i;
		end
	end

	// forwarding keeps an empty queue first-word-fall-through
	always_ff @(posedge clk_i)
	begin
		if (wr_i && (waddr_i == raddr_i))
		begin
			rdata_o <= wdata_i;
		end
		else
		begin
			rdata_o <= mem_reg[raddr_i];
		end
	end

endmodule

`default_nettype wire

/* File: lsg_fifo.sv */
// lsg_fifo.sv: output queue of the sequence generator, valid/ready on both sides.
// assumes one clock and an active-low asynchronous reset; DEPTH is a power of two.

`timescale 1ns/10ps
`default_nettype none

module lsg_fifo #(
	parameter int unsigned DW    = 8,
	parameter int unsigned DEPTH = 8
) (
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_n_i,
	// fill side
	input  wire logic                     in_valid_i,
	output logic                          in_ready_o,
	input  wire logic [DW-1:0]            in_data_i,
	// drain side
	output logic                          out_valid_o,
	input  wire logic                     out_ready_i,
	output logic      [DW-1:0]            out_data_o,
	// fill level
	output logic      [$clog2(DEPTH):0]   level_o
);

	localparam int unsigned AW = $clog2(DEPTH);

	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW-1:0] rd_ptr_next;
	logic [AW:0]   count_reg;
	logic          push;
	logic          pop;

	assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
	assign level_o     = count_reg;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	lsg_mem #(
		.DW (DW),
		.AW (AW)
	) u_mem (
		.clk_i   (clk_i),
		.wr_i    (push),
		.waddr_i (wr_ptr_reg),
		.wdata_i (in_data_i),
		.raddr_i (rd_ptr_next),
		.rdata_o (out_data_o)
	);

endmodule

`default_nettype wire

/* File: lsg_gen.sv */
// lsg_gen.sv: linear feedback shift register with reloadable seed, restart, hold,
// an output queue and a small register port.
// assumes synchronous inputs on clk_i, WIDTH from 2 to 32, and a seed that is not
// the lock value of the chosen gate.

`timescale 1ns/10ps
`default_nettype none
`include "lsg_defines.svh"

module lsg_gen #(
	parameter int unsigned          WIDTH      = `LSG_DEF_WIDTH,
	parameter logic [WIDTH-1:0]     POLY       = `LSG_DEF_POLY,
	parameter logic [WIDTH-1:0]     SEED       = `LSG_DEF_SEED,
	parameter lsg_pkg::lsg_struct_e STRUCT     = lsg_pkg::LSG_FIB,
	parameter lsg_pkg::lsg_gate_e   GATE       = lsg_pkg::LSG_XOR,
	parameter bit                   RELOAD     = 1'b1,
	parameter bit                   PAR_IN     = 1'b1,
	parameter bit                   PAR_OUT    = 1'b1,
	parameter int unsigned          FIFO_DEPTH = `LSG_DEF_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           rst_n_i,
	// sequence control
	input  wire logic                           restart_i,
	input  wire logic                           en_i,
	input  wire logic                           load_i,
	input  wire logic [WIDTH-1:0]               seed_par_i,
	input  wire logic                           seed_ser_i,
	// sequence output
	output logic                                dout_valid_o,
	input  wire logic                           dout_ready_i,
	output logic      [(PAR_OUT ? WIDTH : 1)-1:0] dout_o,
	// register port
	input  wire logic [`LSG_REG_AW-1:0]         reg_addr_i,
	input  wire logic [31:0]                    reg_wdata_i,
	input  wire logic                           reg_wr_i,
	input  wire logic                           reg_rd_i,
	output logic      [31:0]                    reg_rdata_o
);

	localparam int unsigned OW = PAR_OUT ? WIDTH : 1;
	localparam int unsigned LW = $clog2(FIFO_DEPTH) + 1;
	localparam logic [WIDTH-1:0] LOCK_VAL = (GATE == lsg_pkg::LSG_XNOR) ? '1 : '0;

	// ------------------------------------------------------------------------
	// next-state function
	// ------------------------------------------------------------------------
	function automatic logic [WIDTH-1:0] lsg_step(input logic [WIDTH-1:0] s);
		logic [WIDTH-1:0] n;
		logic             fb;
		logic             inv;
		n   = '0;
		inv = (GATE == lsg_pkg::LSG_XNOR);
		fb  = s[WIDTH-1];
		if (STRUCT == lsg_pkg::LSG_FIB)
		begin
			// one gate at the head over all taps, result into the first stage
			for (int i = 1; i < WIDTH; i++)
			begin
				if (POLY[i])
				begin
					fb = fb ^ s[i-1];
				end
			end
			n = {s[WIDTH-2:0], fb ^ inv};
		end
		else
		begin
			// one gate per tap, each fed by the last stage
			n[0] = s[WIDTH-1];
			for (int i = 1; i < WIDTH; i++)
			begin
				n[i] = POLY[i] ? (s[i-1] ^ s[WIDTH-1] ^ inv) : s[i-1];
			end
		end
		return n;
	endfunction

	// ------------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------------
	logic [WIDTH-1:0]        lfsr_reg;
	logic [WIDTH-1:0]        lfsr_next;
	logic                    run_reg;
	logic                    soft_rst_reg;
	logic [31:0]             rdata_reg;
	logic                    fifo_in_ready;
	logic [LW-1:0]           fifo_level;
	logic [OW-1:0]           push_data;
	logic                    do_restart;
	logic                    do_load;
	logic                    do_step;
	lsg_pkg::lsg_act_e       act;

	// ------------------------------------------------------------------------
	// action select
	// ------------------------------------------------------------------------
	// the queue stalls stepping, so no value is ever dropped at the output
	assign do_restart = restart_i || soft_rst_reg;
	assign do_load    = RELOAD && load_i;
	assign do_step    = en_i && run_reg && fifo_in_ready;

	always_comb
	begin
		if (do_restart)
		begin
			act = lsg_pkg::LSG_ACT_RESTART;
		end
		else if (do_load)
		begin
			act = lsg_pkg::LSG_ACT_LOAD;
		end
		else if (do_step)
		begin
			act = lsg_pkg::LSG_ACT_STEP;
		end
		else
		begin
			act = lsg_pkg::LSG_ACT_HOLD;
		end
	end

	always_comb
	begin
		case (act)
			lsg_pkg::LSG_ACT_RESTART:
			begin
				lfsr_next = SEED;
			end
			lsg_pkg::LSG_ACT_LOAD:
			begin
				if (PAR_IN)
				begin
					lfsr_next = seed_par_i;
				end
				else
				begin
					lfsr_next = {lfsr_reg[WIDTH-2:0], seed_ser_i};
				end
			end
			lsg_pkg::LSG_ACT_STEP:
			begin
				lfsr_next = lsg_step(lfsr_reg);
			end
			lsg_pkg::LSG_ACT_HOLD:
			begin
				lfsr_next = lfsr_reg;
			end
			default:
			begin
				lfsr_next = lfsr_reg;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// chain register
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			lfsr_reg <= SEED;
		end
		else
		begin
			lfsr_reg <= lfsr_next;
		end
	end

	// ------------------------------------------------------------------------
	// output queue
	// ------------------------------------------------------------------------
	// the value pushed is the one the chain shows before it steps
	assign push_data = PAR_OUT ? OW'(lfsr_reg) : OW'(lfsr_reg[WIDTH-1]);

	lsg_fifo #(
		.DW    (OW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (act == lsg_pkg::LSG_ACT_STEP),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (push_data),
		.out_valid_o (dout_valid_o),
		.out_ready_i (dout_ready_i),
		.out_data_o  (dout_o),
		.level_o     (fifo_level)
	);

	// ------------------------------------------------------------------------
	// register port
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			run_reg <= `LSG_CTRL_RUN_RST;
		end
		else if (reg_wr_i && (reg_addr_i == `LSG_OFF_CTRL))
		begin
			run_reg <= reg_wdata_i[`LSG_CTRL_RUN_BIT];
		end
	end

	// software restart is a one-cycle pulse, it never sticks
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			soft_rst_reg <= 1'h0;
		end
		else
		begin
			soft_rst_reg <= reg_wr_i && (reg_addr_i == `LSG_OFF_CTRL)
				&& reg_wdata_i[`LSG_CTRL_RST_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdata_reg <= 32'h0;
		end
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				`LSG_OFF_CTRL:
				begin
					rdata_reg <= 32'(run_reg);
				end
				`LSG_OFF_STATE:
				begin
					rdata_reg <= 32'(lfsr_reg);
				end
				`LSG_OFF_LEVEL:
				begin
					rdata_reg <= 32'(fifo_level);
				end
				default:
				begin
					rdata_reg <= 32'h0;
				end
			endcase
		end
		else
		begin
			rdata_reg <= 32'h0;
		end
	end

	assign reg_rdata_o = rdata_reg;

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	a_poly_lsb_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		POLY[0] == 1'b1)
		else $error("tap polynomial lowest bit is not 1");

	a_restart_seed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		restart_i |=> (lfsr_reg == SEED))
		else $error("restart did not restore the build seed");

	a_restart_over_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(restart_i && load_i && en_i)
		|=> (lfsr_reg == SEED) && (fifo_level <= $past(fifo_level)))
		else $error("restart lost priority over load");

	a_par_load_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(RELOAD && PAR_IN && load_i && !restart_i && !soft_rst_reg)
		|=> (lfsr_reg == $past(seed_par_i)))
		else $error("parallel load did not overwrite the chain");

	a_ser_load_shift: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(RELOAD && !PAR_IN && load_i && !restart_i && !soft_rst_reg)
		|=> (lfsr_reg[0] == $past(seed_ser_i))
		&& (lfsr_reg[WIDTH-1:1] == $past(lfsr_reg[WIDTH-2:0])))
		else $error("serial load did not shift the seed bit in");

	a_hold_when_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!en_i && !load_i && !restart_i && !soft_rst_reg)
		|=> $stable(lfsr_reg) ##0 (fifo_level <= $past(fifo_level)))
		else $error("chain moved while enable was low");

	a_fib_shift_path: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(STRUCT == lsg_pkg::LSG_FIB && act == lsg_pkg::LSG_ACT_STEP)
		|=> (lfsr_reg[WIDTH-1:1] == $past(lfsr_reg[WIDTH-2:0])))
		else $error("chained step did not shift toward the last stage");

	a_gal_head_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(STRUCT == lsg_pkg::LSG_GAL && act == lsg_pkg::LSG_ACT_STEP)
		|=> (lfsr_reg[0] == $past(lfsr_reg[WIDTH-1])))
		else $error("distributed step did not feed the last stage to the head");

	a_gate_lock_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(STRUCT == lsg_pkg::LSG_GAL && act == lsg_pkg::LSG_ACT_STEP && lfsr_reg == LOCK_VAL)
		|=> (lfsr_reg == LOCK_VAL))
		else $error("lock value of the gate kind did not lock");

	a_step_pushes_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(act == lsg_pkg::LSG_ACT_STEP && !dout_valid_o)
		|=> dout_valid_o && (dout_o == $past(push_data)))
		else $error("stepped value did not reach the output");

	a_full_stalls_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!fifo_in_ready && !load_i && !restart_i && !soft_rst_reg) |=> $stable(lfsr_reg))
		else $error("chain stepped while the queue was full");

	c_restart_seen: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		restart_i ##1 en_i ##1 en_i);

	c_load_then_step: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		load_i ##1 (act == lsg_pkg::LSG_ACT_STEP));

	c_queue_full: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		!fifo_in_ready ##1 dout_ready_i);

	c_hold_resume: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		!en_i ##1 !en_i ##1 (act == lsg_pkg::LSG_ACT_STEP));

endmodule

`default_nettype wire

/* File: lsg_sink.sv */
// lsg_sink.sv: consumer model at the far side of the generator's output queue.
// assumes one clock; the bench sets the pacing, the model only answers ready.

`timescale 1ns/10ps
`default_nettype none

module lsg_sink (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// pacing from the bench
	input  wire logic stall_i,
	input  wire logic slow_i,
	// queue side
	input  wire logic valid_i,
	output logic      ready_o,
	output logic      take_o
);
	// ----------------------------------------------------------------------------
	// pacing
	// ----------------------------------------------------------------------------
	logic ph_reg;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ph_reg <= 1'b0;
		else
			ph_reg <= ~ph_reg;
	end

	// slow mode takes only every other cycle, so a word must stand while unread
	assign ready_o = !stall_i && (!slow_i || ph_reg);
	assign take_o  = valid_i && ready_o;
endmodule

`default_nettype wire

/* File: test_lsg_gen.sv */
// test_lsg_gen.sv: self-checking bench, one parallel chained instance and one
// serial distributed exclusive-nor instance sharing the controls.
// assumes the default build values of lsg_defines.svh.

`timescale 1ns/10ps
`default_nettype none
`include "lsg_defines.svh"

module test_lsg_gen;
	// ----------------------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------------------
	localparam logic [7:0] POLY = `LSG_DEF_POLY;
	localparam logic [7:0] SEED = `LSG_DEF_SEED;
	logic        clk, rst_n, restart, en, load, ser, stall, slow;
	logic        valid1, valid2, ready, take, dout2;
	logic [7:0]  par, dout1, e1, e2;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, rdata;
	logic        reg_wr, reg_rd;
	int          n_mismatch, n_checks, cyc;

	lsg_gen i_dut (.clk_i(clk), .rst_n_i(rst_n), .restart_i(restart), .en_i(en),
		.load_i(load), .seed_par_i(par), .seed_ser_i(ser), .dout_valid_o(valid1),
		.dout_ready_i(ready), .dout_o(dout1), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata));
	lsg_gen #(.STRUCT(lsg_pkg::LSG_GAL), .GATE(lsg_pkg::LSG_XNOR), .PAR_IN(1'b0),
		.PAR_OUT(1'b0)) i_dut_ser (.clk_i(clk), .rst_n_i(rst_n), .restart_i(restart),
		.en_i(en), .load_i(load), .seed_par_i(par), .seed_ser_i(ser),
		.dout_valid_o(valid2), .dout_ready_i(ready), .dout_o(dout2), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o());
	lsg_sink i_sink (.clk_i(clk), .rst_n_i(rst_n), .stall_i(stall), .slow_i(slow),
		.valid_i(valid1), .ready_o(ready), .take_o(take));

	// ----------------------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------------------
	function automatic logic [7:0] nxt(input logic [7:0] s, input bit gal, input bit xn);
		logic [7:0] n;
		logic       fb;
		fb = s[7];
		for (int i = 1; i < 8; i++)
			if (POLY[i])
				fb = fb ^ s[i-1];
		n = {s[6:0], fb ^ xn};
		if (gal)
			for (int i = 0; i < 8; i++)
				n[i] = (i == 0) ? s[7] : (POLY[i] ? s[i-1] ^ s[7] ^ xn : s[i-1]);
		return n;
	endfunction

	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		@(negedge clk);
		chk(rdata === d, "register read");
		@(posedge clk);
	endtask

	// pops n words and compares both instances; leaves e1/e2 at the chains' values
	task automatic drain(input int n, input logic slw);
		int got;
		int t;
		got = 0;
		t = 0;
		stall <= 1'b0;
		slow <= slw;
		while (got < n && t < 100)
		begin
			@(negedge clk);
			t++;
			if (take)
			begin
				chk(dout1 === e1, "parallel word");
				chk(dout2 === e2[7], "serial bit");
				e1 = nxt(e1, 0, 0);
				e2 = nxt(e2, 1, 1);
				got++;
			end
			@(posedge clk);
		end
		stall <= 1'b1;
		@(negedge clk);
		chk(got == n && valid1 === 1'b0 && valid2 === 1'b0, "word count");
		@(posedge clk);
	endtask

	task automatic steps(input int k);
		en <= 1'b1;
		repeat (k) @(posedge clk);
		en <= 1'b0;
	endtask

	// ----------------------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------------------
	task automatic t_fill;
		steps(12);
		rd(`LSG_OFF_LEVEL, 32'h8);
		repeat (4) @(posedge clk);
		drain(8, 1'b0);
		rd(`LSG_OFF_STATE, {24'h0, e1});
		$display("test fill done");
	endtask

	task automatic t_load;
		par  <= 8'hA5;
		load <= 1'b1;
		en   <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		steps(2);
		e1 = 8'hA5;
		e2 = {e2[6:0], 1'b0};
		drain(2, 1'b0);
		$display("test load done");
	endtask

	task automatic t_restart;
		restart <= 1'b1;
		load    <= 1'b1;
		par     <= 8'hFF;
		en      <= 1'b1;
		@(posedge clk);
		restart <= 1'b0;
		load    <= 1'b0;
		steps(1);
		e1 = SEED;
		e2 = SEED;
		drain(1, 1'b0);
		$display("test restart done");
	endtask

	task automatic t_serial;
		logic [7:0] v;
		v = 8'h3C;
		par  <= v;
		load <= 1'b1;
		en   <= 1'b1;
		for (int i = 7; i >= 0; i--)
		begin
			ser <= v[i];
			@(posedge clk);
		end
		load <= 1'b0;
		steps(3);
		e1 = 8'h3C;
		e2 = 8'h3C;
		drain(3, 1'b1);
		$display("test serial done");
	endtask

	task automatic t_regs;
		rd(`LSG_OFF_CTRL, 32'h1);
		rd(4'hC, 32'h0);
		par  <= 8'h5A;
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		wr(`LSG_OFF_CTRL, 32'h2);
		repeat (2) @(posedge clk);
		rd(`LSG_OFF_STATE, {24'h0, SEED});
		rd(`LSG_OFF_CTRL, 32'h0);
		steps(2);
		rd(`LSG_OFF_STATE, {24'h0, SEED});
		wr(`LSG_OFF_CTRL, 32'h1);
		rd(`LSG_OFF_CTRL, 32'h1);
		$display("test regs done");
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------------------
	// run
	// ----------------------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			$display("BAD %0t run too long", $time);
			results();
		end
	end

	initial
	begin
		{rst_n, restart, en, load, ser, slow, reg_wr, reg_rd} = '0;
		stall = 1'b1;
		par = 8'h00;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		n_mismatch = 0;
		n_checks = 0;
		cyc = 0;
		e1 = SEED;
		e2 = SEED;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_fill();
		t_load();
		t_restart();
		t_serial();
		results();
	end
endmodule

`default_nettype wire
